// ==== logic/crbu_branch_unit.sv ====
// Decode and execute of the one-word conditional relative branches
//
// Functional notes
// (RULE1) Unsigned at-most (nibble 0110) is taken on carry clear or zero set.
// (RULE2) Signed below (nibble 0101) is taken when sign and overflow differ.
// (RULE3) Unsigned below is carry-clear: nibble 1001, taken on carry zero.
// (RULE4) Negative branch (nibble 0011) is taken when negative flag is set.
// (RULE5) Sign-clear (nibble 1011) is taken only when negative is clear.
// (RULE6) No-overflow (nibble 1000) is taken only when overflow is clear.
// (RULE7) A taken branch loads PC with (PC + 2) plus twice the signed literal.
// (RULE8) A taken branch adds a cycle with a NOP in the instruction register.
// (RULE9) The low 16 opcode bits are a signed word distance from PC + 2.
// (RULE10) The offset reaches 32K instructions either way from PC + 2.
// (RULE11) One word; 1 cycle not taken, 2 or 4 cycles taken by core variant.
// (RULE12) Not taken continues at PC + 2; no status flag changes either way.
module crbu_branch_unit
   import crbu_pkg::*;
(
   input wire logic i_clk, // Core clock
   input wire logic i_rst_n, // Synchronous reset, active low
   input wire crbu_pkg::crbu_instr_t i_instr, // Instruction word
   input wire logic i_instr_valid, // Instruction word present
   input wire logic [crbu_pkg::PC_W-1:0] i_pc, // Address of the instruction
   input wire crbu_pkg::crbu_status_word_t i_status_word, // Status flags
   input wire crbu_pkg::crbu_reg_req_t i_reg, // Register port request
   output logic o_ack, // Instruction taken by this unit
   output logic o_resolve, // Branch outcome valid, one cycle
   output logic o_taken, // Outcome of the last branch
   output logic [crbu_pkg::PC_W-1:0] o_pc_target, // Next PC to fetch
   output logic o_nop_insert, // Put a NOP in the instruction register
   output logic o_stall, // Hold fetch while flushing
   output logic [crbu_pkg::DATA_W-1:0] o_rdata // Register read data
);

   import crbu_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Byte displacement of a word literal, sign extended to the PC width
   function automatic logic [PC_W-1:0] byte_offset(
      input logic [LIT_W-1:0] lit
   );
      logic [PC_W-1:0] ext;
      ext = {{(PC_W - LIT_W){lit[LIT_W-1]}}, lit};
      byte_offset = ext << OFFSET_SHIFT; // RULE9
   endfunction : byte_offset

   // Taken-branch destination
   function automatic logic [PC_W-1:0] branch_dest(
      input logic [PC_W-1:0] pc,
      input logic [LIT_W-1:0] lit
   );
      // Wraps modulo the PC width, so 32K words reach either way
      branch_dest = pc + PC_STEP + byte_offset(lit); // RULE7 RULE10
   endfunction : branch_dest

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   crbu_state_t state_r;
   crbu_state_t state_nxt;
   logic [1:0] extra_r;
   logic [DATA_W-1:0] ctrl_r;
   logic [DATA_W-1:0] taken_cnt_r;
   logic [DATA_W-1:0] ntaken_cnt_r;
   logic [DATA_W-1:0] rdata_r;
   logic resolve_r;
   logic taken_r;
   logic [PC_W-1:0] target_r;
   logic cond_known;
   logic cond_taken;
   logic accept;
   logic unit_en;
   logic slow_variant;

   assign unit_en = ctrl_r[CTRL_EN_BIT];
   assign slow_variant = ctrl_r[CTRL_SLOW_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   crbu_cond_eval u_cond_eval (
      .i_cond (i_instr.cond),
      .i_flags (i_status_word),
      .o_known (cond_known),
      .o_taken (cond_taken)
   );

   // A new branch is accepted only while no flush is in progress
   assign accept = unit_en && i_instr_valid && (state_r == ST_IDLE) &&
                   (i_instr.prefix == GROUP_PREFIX) && cond_known;
   assign o_ack = accept;

   ////////////////////////////////////////////////////////////////////////////
   // Outcome and target

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         resolve_r <= 1'b0;
         taken_r <= 1'b0;
         target_r <= '0;
      end else begin
         resolve_r <= accept;
         if (accept) begin
            taken_r <= cond_taken;
            if (cond_taken) begin
               target_r <= branch_dest(i_pc, i_instr.branch_offset_literal);
            end else begin
               // Status flags are only read here, never written
               target_r <= i_pc + PC_STEP; // RULE12
            end
         end
      end
   end

   assign o_resolve = resolve_r;
   assign o_taken = taken_r;
   assign o_pc_target = target_r;

   ////////////////////////////////////////////////////////////////////////////
   // Flush sequencer

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (accept && cond_taken) begin
               state_nxt = ST_FLUSH; // RULE8
            end
         end
         ST_FLUSH: begin
            if (extra_r == 2'h1) begin
               state_nxt = ST_IDLE; // RULE11
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Variant is latched at accept so a control write cannot cut a flush short
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         extra_r <= 2'h0;
      end else if (accept && cond_taken) begin
         extra_r <= slow_variant ? EXTRA_SLOW : EXTRA_FAST; // RULE11
      end else if (state_r == ST_FLUSH) begin
         extra_r <= extra_r - 2'h1;
      end
   end

   assign o_nop_insert = (state_r == ST_FLUSH); // RULE8
   assign o_stall = (state_r == ST_FLUSH);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_r <= CTRL_RESET;
      end else if (i_reg.wr && i_reg.addr == REG_CTRL) begin
         ctrl_r <= i_reg.wdata & 16'h0003;
      end
   end

   // A software write in the same cycle as a count loads the written value plus one
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         taken_cnt_r <= CNT_RESET;
      end else if (accept && cond_taken) begin
         if (i_reg.wr && i_reg.addr == REG_TAKEN_CNT) begin
            taken_cnt_r <= i_reg.wdata + 16'h0001;
         end else begin
            taken_cnt_r <= taken_cnt_r + 16'h0001;
         end
      end else if (i_reg.wr && i_reg.addr == REG_TAKEN_CNT) begin
         taken_cnt_r <= i_reg.wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ntaken_cnt_r <= CNT_RESET;
      end else if (accept && !cond_taken) begin
         if (i_reg.wr && i_reg.addr == REG_NTAKEN_CNT) begin
            ntaken_cnt_r <= i_reg.wdata + 16'h0001;
         end else begin
            ntaken_cnt_r <= ntaken_cnt_r + 16'h0001;
         end
      end else if (i_reg.wr && i_reg.addr == REG_NTAKEN_CNT) begin
         ntaken_cnt_r <= i_reg.wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_r <= '0;
      end else if (i_reg.rd) begin
         case (i_reg.addr)
            REG_CTRL: rdata_r <= ctrl_r;
            REG_STAT: begin
               rdata_r <= '0;
               rdata_r[STAT_TAKEN_BIT] <= taken_r;
               rdata_r[STAT_BUSY_BIT] <= (state_r == ST_FLUSH);
               rdata_r[STAT_SLOW_BIT] <= slow_variant;
            end
            REG_TAKEN_CNT: rdata_r <= taken_cnt_r;
            REG_NTAKEN_CNT: rdata_r <= ntaken_cnt_r;
            default: rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   assign o_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_at_most_test: assert property ( // RULE1
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && i_instr.cond == OPC_AT_MOST) |=>
         (o_taken == (!$past(i_status_word.c) || $past(i_status_word.z))))
      else $error("unsigned at-most outcome wrong");

   a_signed_below_test: assert property ( // RULE2
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && i_instr.cond == OPC_SIGNED_BELOW) |=>
         (o_taken == ($past(i_status_word.n) != $past(i_status_word.ov))))
      else $error("signed below outcome wrong");

   a_carry_clear_test: assert property ( // RULE3
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && i_instr.cond == OPC_UNSIGNED_BELOW) |=>
         (o_taken == !$past(i_status_word.c)))
      else $error("carry clear outcome wrong");

   a_negative_test: assert property ( // RULE4
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && i_instr.cond == OPC_NEGATIVE) |=>
         (o_taken == $past(i_status_word.n)))
      else $error("negative outcome wrong");

   a_sign_clear_test: assert property ( // RULE5
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && i_instr.cond == OPC_SIGN_CLEAR) |=>
         (o_taken == !$past(i_status_word.n)))
      else $error("sign clear outcome wrong");

   a_no_ovf_test: assert property ( // RULE6
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && i_instr.cond == OPC_NO_OVF) |=>
         (o_taken == !$past(i_status_word.ov)))
      else $error("no overflow outcome wrong");

   a_taken_target: assert property ( // RULE7 RULE9
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && cond_taken) |=>
         (o_resolve && o_pc_target == $past(i_pc) + PC_STEP +
          byte_offset($past(i_instr.branch_offset_literal))))
      else $error("taken target wrong");

   a_far_back_reach: assert property ( // RULE10
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && cond_taken && i_instr.branch_offset_literal == 16'h8000) |=>
         (o_pc_target == $past(i_pc) + PC_STEP - 24'h010000))
      else $error("backward reach wrong");

   a_nop_after_taken: assert property ( // RULE8
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_resolve && o_taken) |-> (o_nop_insert && o_stall))
      else $error("no NOP after taken branch");

   a_fast_cycle_count: assert property ( // RULE11
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && cond_taken && !slow_variant) |=>
         o_nop_insert ##1 (!o_nop_insert && !o_stall))
      else $error("fast taken branch not 2 cycles");

   a_slow_cycle_count: assert property ( // RULE11
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && cond_taken && slow_variant) |=>
         o_nop_insert [*3] ##1 (!o_nop_insert && !o_stall))
      else $error("slow taken branch not 4 cycles");

   a_not_taken_flow: assert property ( // RULE12 RULE11
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && !cond_taken) |=>
         (!o_taken && !o_stall && o_pc_target == $past(i_pc) + PC_STEP))
      else $error("not taken branch mishandled");

   // Handshake and hold checks around the flush
   a_flush_refuses: assert property ( // RULE8
      @(posedge i_clk) disable iff (!i_rst_n)
      o_stall |-> !o_ack)
      else $error("branch accepted during NOP cycles");

   a_resolve_follows: assert property ( // RULE11
      @(posedge i_clk) disable iff (!i_rst_n)
      o_ack |=> o_resolve)
      else $error("accepted branch not resolved");

   a_resolve_single: assert property ( // RULE11
      @(posedge i_clk) disable iff (!i_rst_n)
      !o_ack |=> !o_resolve)
      else $error("resolve without an accepted branch");

   a_outcome_holds: assert property ( // RULE12
      @(posedge i_clk) disable iff (!i_rst_n)
      !o_ack |=> ($stable(o_taken) && $stable(o_pc_target)))
      else $error("outcome changed without a branch");

   a_far_fwd_reach: assert property ( // RULE10
      @(posedge i_clk) disable iff (!i_rst_n)
      (accept && cond_taken && i_instr.branch_offset_literal == 16'h7FFF) |=>
         (o_pc_target == $past(i_pc) + PC_STEP + 24'h00FFFE))
      else $error("forward reach wrong");

   a_no_nop_not_taken: assert property ( // RULE11
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_resolve && !o_taken) |-> !o_nop_insert)
      else $error("NOP after branch not taken");

   // Three NOP cycles is the slow variant's ceiling
   a_flush_bounded: assert property ( // RULE11
      @(posedge i_clk) disable iff (!i_rst_n)
      o_stall |-> ##[1:3] !o_stall)
      else $error("NOP cycles run too long");

endmodule : crbu_branch_unit

// ==== logic/crbu_pkg.sv ====
// Shared constants and types for the conditional relative branch unit
package crbu_pkg;

   // Datapath widths
   localparam int PC_W = 24;
   localparam int LIT_W = 16;
   localparam int NIB_W = 4;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Opcode fields
   localparam logic [3:0] GROUP_PREFIX = 4'h3;
   localparam logic [3:0] OPC_AT_MOST = 4'h6;
   localparam logic [3:0] OPC_SIGNED_BELOW = 4'h5;
   localparam logic [3:0] OPC_UNSIGNED_BELOW = 4'h9;
   localparam logic [3:0] OPC_NEGATIVE = 4'h3;
   localparam logic [3:0] OPC_SIGN_CLEAR = 4'hB;
   localparam logic [3:0] OPC_NO_OVF = 4'h8;

   // Program counter arithmetic
   localparam logic [PC_W-1:0] PC_STEP = 24'h000002;
   localparam int OFFSET_SHIFT = 1;

   // Cycles spent with a NOP after a taken branch (total 2 or 4)
   localparam logic [1:0] EXTRA_FAST = 2'h1;
   localparam logic [1:0] EXTRA_SLOW = 2'h3;

   // Register map (byte addresses)
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
   localparam logic [ADDR_W-1:0] REG_TAKEN_CNT = 4'h8;
   localparam logic [ADDR_W-1:0] REG_NTAKEN_CNT = 4'hC;

   // Control register fields
   localparam int CTRL_SLOW_BIT = 0;
   localparam int CTRL_EN_BIT = 1;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0002;

   // Status register fields
   localparam int STAT_TAKEN_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_SLOW_BIT = 2;
   localparam logic [DATA_W-1:0] CNT_RESET = 16'h0000;

   // Processor status word flags seen by the unit
   typedef struct packed {
      logic ov;
      logic n;
      logic z;
      logic c;
   } crbu_status_word_t;

   // One-word branch instruction layout
   typedef struct packed {
      logic [NIB_W-1:0] prefix;
      logic [NIB_W-1:0] cond;
      logic [LIT_W-1:0] branch_offset_literal;
   } crbu_instr_t;

   // Register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } crbu_reg_req_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_FLUSH = 2'b10
   } crbu_state_t;

endpackage : crbu_pkg

// ==== logic/crbu_cond_eval.sv ====
// Condition decoder: group membership and flag test for one opcode nibble
module crbu_cond_eval
   import crbu_pkg::*;
(
   input wire logic [3:0] i_cond, // Opcode nibble after the prefix
   input wire crbu_pkg::crbu_status_word_t i_flags, // Live status flags
   output logic o_known, // Nibble belongs to this group
   output logic o_taken // Branch condition holds
);

   always_comb begin
      o_known = 1'b1;
      o_taken = 1'b0;
      case (i_cond)
         OPC_AT_MOST: begin
            o_taken = !i_flags.c || i_flags.z; // RULE1
         end
         OPC_SIGNED_BELOW: begin
            o_taken = i_flags.n ^ i_flags.ov; // RULE2
         end
         OPC_UNSIGNED_BELOW: begin
            // Carry-clear shares this encoding
            o_taken = !i_flags.c; // RULE3
         end
         OPC_NEGATIVE: begin
            o_taken = i_flags.n; // RULE4
         end
         OPC_SIGN_CLEAR: begin
            o_taken = !i_flags.n; // RULE5
         end
         OPC_NO_OVF: begin
            o_taken = !i_flags.ov; // RULE6
         end
         default: begin
            o_known = 1'b0;
            o_taken = 1'b0;
         end
      endcase
   end

endmodule : crbu_cond_eval

// ==== bench/crbu_fetch_model.sv ====
// Fetch-side model: queues instruction words, holds each until accepted or skipped
module crbu_fetch_model
   import crbu_pkg::*;
(
   input wire logic i_clk, // Core clock
   input wire logic i_load, // Queue a word
   input wire logic i_skip, // Drop the front word
   input wire crbu_pkg::crbu_instr_t i_instr, // Word to queue
   input wire logic [crbu_pkg::PC_W-1:0] i_pc, // Its address
   input wire crbu_pkg::crbu_status_word_t i_flags, // Its flags
   input wire logic i_ack, // Accept from the unit
   output logic o_valid, // Word presented
   output crbu_pkg::crbu_instr_t o_instr, // Presented word
   output logic [crbu_pkg::PC_W-1:0] o_pc, // Presented address
   output crbu_pkg::crbu_status_word_t o_flags // Presented flags
);
   timeunit 1ns;
   timeprecision 1ps;
   import crbu_pkg::*;
   logic [51:0] q[$];
   initial begin
      o_valid = 1'b0;
      o_instr = '0;
      o_pc = '0;
      o_flags = '0;
   end
   // A refused word stays presented; only an accept or a skip retires it
   always @(posedge i_clk) begin
      if ((i_ack || i_skip) && q.size() != 0)
         void'(q.pop_front());
      if (i_load)
         q.push_back({i_instr, i_pc, i_flags});
      o_valid <= q.size() != 0;
      if (q.size() != 0)
         {o_instr, o_pc, o_flags} <= q[0];
      else begin
         // Idle lines toggle so stale words cannot pass for fresh ones
         o_instr <= ~o_instr;
         o_pc <= ~o_pc;
      end
   end
endmodule : crbu_fetch_model

// ==== bench/crbu_branch_unit_tb.sv ====
// Self-checking bench for the conditional relative branch unit
module crbu_branch_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import crbu_pkg::*;
   typedef struct packed {
      logic taken;
      logic [PC_W-1:0] target;
      logic [1:0] nops;
   } crbu_tb_exp_t;
   localparam logic [3:0] NIB_TAB [6] = '{OPC_AT_MOST, OPC_SIGNED_BELOW,
      OPC_UNSIGNED_BELOW, OPC_NEGATIVE, OPC_SIGN_CLEAR, OPC_NO_OVF};
   logic clk, rst_n, ld, skip, pv, ack, resolve, taken, nop, stall, rd_d;
   logic slow;
   crbu_instr_t ld_instr, p_instr;
   logic [PC_W-1:0] ld_pc, p_pc, target;
   crbu_status_word_t ld_flags, p_flags;
   crbu_reg_req_t req;
   logic [DATA_W-1:0] rdata;
   crbu_tb_exp_t exq[$], e;
   logic [DATA_W-1:0] rq[$];
   int fail_count, check_count, run, expn, tcnt, ncnt;

   crbu_fetch_model fetch_u (.i_clk(clk), .i_load(ld), .i_skip(skip),
      .i_instr(ld_instr), .i_pc(ld_pc), .i_flags(ld_flags), .i_ack(ack),
      .o_valid(pv), .o_instr(p_instr), .o_pc(p_pc), .o_flags(p_flags));
   crbu_branch_unit dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_instr(p_instr),
      .i_instr_valid(pv), .i_pc(p_pc), .i_status_word(p_flags),
      .i_reg(req), .o_ack(ack), .o_resolve(resolve), .o_taken(taken),
      .o_pc_target(target), .o_nop_insert(nop), .o_stall(stall),
      .o_rdata(rdata));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic cond_hit(logic [3:0] c, crbu_status_word_t f);
      case (c)
         4'h6: return !f.c || f.z;
         4'h5: return f.n ^ f.ov;
         4'h9: return !f.c;
         4'h3: return f.n;
         4'hB: return !f.n;
         default: return !f.ov;
      endcase
   endfunction : cond_hit

   task automatic check(logic [39:0] got, logic [39:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic final_report;
      if (fail_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   // Queues one word; the caller ends a burst with idle
   task automatic br(logic [3:0] pre, logic [3:0] c, logic [15:0] lit,
      logic [PC_W-1:0] pc, crbu_status_word_t f);
      crbu_tb_exp_t x;
      @(posedge clk);
      ld <= 1'b1;
      ld_instr <= {pre, c, lit};
      ld_pc <= pc;
      ld_flags <= f;
      if (pre == GROUP_PREFIX && c inside {NIB_TAB}) begin
         x.taken = cond_hit(c, f);
         x.target = pc + PC_STEP;
         if (x.taken)
            x.target = x.target + {{7{lit[15]}}, lit, 1'b0};
         x.nops = x.taken ? (slow ? 2'h3 : 2'h1) : 2'h0;
         exq.push_back(x);
         tcnt += x.taken;
         ncnt += !x.taken;
      end
   endtask : br

   task automatic idle;
      @(posedge clk);
      ld <= 1'b0;
   endtask : idle

   task automatic reg_op(logic w, logic [3:0] a, logic [15:0] d);
      @(posedge clk);
      req <= '{a, w ? d : 16'h0000, w, !w};
      if (!w)
         rq.push_back(d);
      @(posedge clk);
      req <= '0;
   endtask : reg_op

   task automatic drain;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((pv === 1'b1 || stall !== 1'b0 || exq.size() != 0)
         && n < 400);
      if (n >= 400) begin
         fail_count++;
         final_report();
      end
   endtask : drain

   task automatic no_ack(int cycles);
      repeat (cycles) begin
         @(posedge clk);
         #1;
         check(ack, 0);
      end
   endtask : no_ack

   ////////////////////////////////////////////////////////////////////////
   // Monitor: outcomes, NOP run length and read data against the notes
   always @(posedge clk) begin
      rd_d <= req.rd;
      if (rd_d) begin
         if (rq.size() == 0)
            check(1, 0);
         else
            check(rdata, rq.pop_front());
      end
      if (rst_n) begin
         check(stall, nop);
         if (nop === 1'b1)
            run++;
         else if (run != 0) begin
            check(run, expn);
            run = 0;
         end
         if (resolve === 1'b1) begin
            if (exq.size() == 0)
               check(1, 0);
            else begin
               e = exq.pop_front();
               check({taken, target}, {e.taken, e.target});
               check(nop, e.taken);
               expn = e.nops;
            end
         end
      end
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      {ld, skip, slow, rd_d} = 4'h0;
      ld_instr = '0;
      ld_pc = '0;
      ld_flags = '0;
      req = '0;
      {fail_count, check_count, run, expn, tcnt, ncnt} = '0;
      void'($urandom(32'h0923));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      reg_op(0, REG_CTRL, CTRL_RESET);
      reg_op(0, REG_STAT, 16'h0000);
      reg_op(0, REG_TAKEN_CNT, CNT_RESET);
      reg_op(0, REG_NTAKEN_CNT, CNT_RESET);
      reg_op(0, 4'h2, 16'h0000);
      // Every condition under every flag pattern, words back to back
      for (int i = 0; i < 6; i++)
         for (int f = 0; f < 16; f++)
            br(GROUP_PREFIX, NIB_TAB[i], 16'($urandom),
               24'($urandom) & 24'hFFFFFE, 4'(f));
      idle();
      drain();
      // Offset extremes with address wrap
      br(GROUP_PREFIX, OPC_NEGATIVE, 16'h7FFF, 24'hFFFFFE, 4'h4);
      br(GROUP_PREFIX, OPC_NEGATIVE, 16'h8000, 24'h000000, 4'h4);
      idle();
      drain();
      // Slow variant: three NOP cycles per taken branch
      reg_op(1, REG_CTRL, 16'h0003);
      slow = 1'b1;
      br(GROUP_PREFIX, OPC_NO_OVF, 16'hFFFF, 24'h001000, 4'h0);
      br(GROUP_PREFIX, OPC_SIGN_CLEAR, 16'h0004, 24'h002000, 4'h0);
      idle();
      drain();
      reg_op(0, REG_STAT, 16'h0005);
      // Disabled unit holds off until enabled again
      reg_op(1, REG_CTRL, 16'h0000);
      slow = 1'b0;
      br(GROUP_PREFIX, OPC_AT_MOST, 16'h0010, 24'h003000, 4'h0);
      idle();
      no_ack(4);
      reg_op(1, REG_CTRL, CTRL_RESET);
      drain();
      // Foreign prefix and foreign nibble are refused
      br(4'h1, OPC_AT_MOST, 16'h0001, 24'h004000, 4'h0);
      br(GROUP_PREFIX, 4'h1, 16'h0001, 24'h004002, 4'h0);
      idle();
      repeat (2) begin
         no_ack(3);
         @(posedge clk);
         skip <= 1'b1;
         @(posedge clk);
         skip <= 1'b0;
      end
      drain();
      reg_op(0, REG_TAKEN_CNT, 16'(tcnt));
      reg_op(0, REG_NTAKEN_CNT, 16'(ncnt));
      repeat (3) @(posedge clk);
      final_report();
   end
endmodule : crbu_branch_unit_tb
